/* File: rtl/sdcti_top.sv */
// device side of an sdram: command decode, bursts, gating and init tracking
// Functional notes
// [RQ1] controller waits one cycle, write data to stop
// [RQ2] controller waits one cycle, write data to access
// [RQ3] gate low suspends internal clock next cycle
// [RQ4] gate high resumes next cycle; commands then
// [RQ5] auto-close write waits four/five clocks before open
// [RQ6] two cycles from last write to close
// [RQ7] write mask acts on same edge
// [RQ8] read mask floats lanes two clocks later
// [RQ9] first write data with the write command
// [RQ10] two cycles after mode load before open/refresh
// [RQ11] close during read floats after read latency
// [RQ12] wait, then two refreshes before use
// [RQ13] repeat two refreshes after interval lapse
// [RQ14] everything sampled on rising clock edge
// [RQ15] four banks, 8192 rows, x16 has 1024 columns
// [RQ16] open row first, then read or write burst
// [RQ17] open: bank selects, thirteen bits pick row
// [RQ18] access: low ten bits pick column
// [RQ19] controller keeps clock steady during accesses
// [RQ20] auto-close budget starts clock plus 7/7.5 ns
// [RQ21] bit ten high closes row after burst
// [RQ22] controller counts gaps per bank and command
`timescale 1ns/10ps
`default_nettype none
module sdcti_top
	import sdcti_pkg::*;
#(
	parameter int REFRESH_CYC = REFRESH_INTERVAL_CYC
) (
	// clock, reset, enable
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              clk_en,
	// command pins
	input  wire logic              cke,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic              bank_select_bit0,
	input  wire logic              bank_select_bit1,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DM_W-1:0]   dqm,
	// data pins
	input  wire logic [DQ_W-1:0]   dq_in,
	output logic      [DQ_W-1:0]   dq_out,
	output logic      [DQ_W-1:0]   dq_oe,
	// status
	input  wire logic              err_clear,
	output logic                   ready,
	output logic                   power_down,
	output logic                   clock_suspend,
	output logic [MODE_LAT_W-1:0]  read_latency_setting,
	output logic [ERR_W-1:0]       protocol_error
);

	// ==========================================================
	// registers
	logic                   gate_ff;
	logic [MODE_W-1:0]      mode_ff;
	sdcti_burst_t           st_ff;
	logic [BANK_W-1:0]      bank_ff;
	logic [COL_W-1:0]       start_col_ff;
	logic [2:0]             idx_ff;
	logic                   auto_ff;
	logic [1:0]             mode_rem_ff;
	logic [1:0]             wr_rem_ff;
	logic [1:0]             ref_cnt_ff;
	logic [31:0]            ref_timer_ff;
	logic                   ready_ff;
	logic                   pd_ff;
	logic                   susp_ff;
	logic [ERR_W-1:0]       err_ff;

	// ==========================================================
	// gating: the gate input sampled on one edge rules the next
	wire logic en = clk_en & gate_ff; // [RQ3] [RQ4]

	always_ff @(posedge core_clk) begin
		if (rst) begin
			gate_ff <= 1'b1;
			pd_ff   <= 1'b0;
			susp_ff <= 1'b0;
		end else if (clk_en) begin
			gate_ff <= cke; // [RQ3] [RQ4]
			pd_ff   <= ~cke & (st_ff == BS_IDLE);
			susp_ff <= ~cke & (st_ff != BS_IDLE);
		end
	end

	// ==========================================================
	// command decode, all taken on the rising edge
	wire sdcti_cmd_t      cmd    = sdcti_cmd_t'({ras_n, cas_n, we_n});
	wire logic            cmd_ok = en & ~cs_n; // [RQ14]
	wire logic [BANK_W-1:0] bank = {bank_select_bit1, bank_select_bit0};
	wire logic is_act = cmd_ok & (cmd == CMD_ACT);
	wire logic is_rd  = cmd_ok & (cmd == CMD_RD);
	wire logic is_wr  = cmd_ok & (cmd == CMD_WR);
	wire logic is_bst = cmd_ok & (cmd == CMD_BST);
	wire logic is_pre = cmd_ok & (cmd == CMD_PRE);
	wire logic is_ref = cmd_ok & (cmd == CMD_REF);
	wire logic is_lmr = cmd_ok & (cmd == CMD_LMR);
	wire logic a10    = addr[AUTO_CLOSE_SELECT_BIT];

	// bank lookup
	logic [BANKS-1:0] open_mask;
	logic [ROW_W-1:0] sel_row;
	wire logic [BANK_W-1:0] cur_bank;

	// an access to a closed bank is dropped
	wire logic rw_req = is_rd | is_wr;
	wire logic start  = rw_req & open_mask[bank]; // [RQ16]

	// a new access, a stop, or a close of this bank ends the burst
	wire logic stop = is_bst | rw_req
		| (is_pre & (a10 | (bank == bank_ff))); // [RQ11]

	// ==========================================================
	// burst addressing: length and order from the mode word
	wire logic [MODE_BL_W-1:0] bl_code = mode_ff[MODE_BL_LSB +: MODE_BL_W];
	wire logic [2:0] bl_mask = (bl_code == 3'h0) ? 3'h0 :
		(bl_code == 3'h1) ? 3'h1 :
		(bl_code == 3'h2) ? 3'h3 : 3'h7;
	wire logic interleave = mode_ff[MODE_ORDER_BIT];
	wire logic lat3 = (mode_ff[MODE_LAT_LSB +: MODE_LAT_W] == LAT_THREE);

	assign cur_bank = start ? bank : bank_ff;
	wire logic [2:0]       cur_idx   = start ? 3'h0 : idx_ff;
	wire logic [COL_W-1:0] cur_start =
		start ? addr[COL_W-1:0] : start_col_ff; // [RQ18]
	wire logic cur_auto = start ? a10 : auto_ff; // [RQ21]
	wire logic [2:0] step = interleave ? (cur_start[2:0] ^ cur_idx)
		: 3'(cur_start[2:0] + cur_idx);
	// column wraps inside the burst-aligned block
	wire logic [2:0] low_col = (step & bl_mask) | (cur_start[2:0] & ~bl_mask);
	wire logic [COL_W-1:0] cur_col = {cur_start[COL_W-1:3], low_col};

	wire logic beat_live  = start | ((st_ff != BS_IDLE) & en & ~stop);
	wire logic beat_write = start ? is_wr : (st_ff == BS_WRITE);
	wire logic beat_last  = (cur_idx == bl_mask);
	wire logic close_auto = beat_live & beat_last & cur_auto; // [RQ21]

	// ==========================================================
	// burst engine
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff        <= BS_IDLE;
			bank_ff      <= '0;
			start_col_ff <= '0;
			idx_ff       <= '0;
			auto_ff      <= 1'b0;
		end else if (en) begin
			case (st_ff)
				BS_IDLE, BS_READ, BS_WRITE: begin
					if (start) begin
						bank_ff      <= bank;
						start_col_ff <= addr[COL_W-1:0];
						auto_ff      <= a10;
						idx_ff       <= 3'h1;
						if (beat_last) begin
							st_ff <= BS_IDLE;
						end else begin
							st_ff <= is_wr ? BS_WRITE : BS_READ; // [RQ16]
						end
					end else if (stop | beat_last) begin
						st_ff <= BS_IDLE;
					end else if (st_ff != BS_IDLE) begin
						idx_ff <= 3'(idx_ff + 3'h1);
					end
				end
				default: begin
					st_ff <= BS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// bank table
	sdcti_bank_table u_banks (
		.core_clk   (core_clk),
		.rst        (rst),
		.en         (en),
		.act        (is_act),
		.act_bank   (bank),
		.act_row    (addr[ROW_W-1:0]), // [RQ15]
		.close_all  (is_pre & a10),
		.close_one  (is_pre & ~a10),
		.close_bank (bank),
		.close_auto (close_auto),
		.auto_bank  (cur_bank),
		.sel_bank   (cur_bank),
		.open_mask  (open_mask),
		.sel_row    (sel_row)
	);

	// ==========================================================
	// store: small flop array, rows alias above the kept row bit
	wire logic [STORE_AW-1:0] st_idx = {cur_bank, sel_row[0], cur_col[2:0]};
	logic [DQ_W-1:0] rd_word;

	genvar l;
	generate
		for (l = 0; l < DM_W; l++) begin : g_lane
			logic [LANE_W-1:0] mem_ff [STORE_DEPTH];
			// write data and its mask ride on the same edge
			always_ff @(posedge core_clk) begin
				if (beat_live & beat_write & ~dqm[l]) begin // [RQ7] [RQ9]
					mem_ff[st_idx] <= dq_in[l*LANE_W +: LANE_W];
				end
			end
			assign rd_word[l*LANE_W +: LANE_W] = mem_ff[st_idx];
		end
	endgenerate

	// ==========================================================
	// read data path with latency and mask delay
	sdcti_read_pipe u_rpipe (
		.core_clk     (core_clk),
		.rst          (rst),
		.adv          (en),
		.launch_valid (beat_live & ~beat_write),
		.launch_data  (rd_word),
		.dqm          (dqm),
		.lat3         (lat3),
		.dq_out       (dq_out),
		.dq_oe        (dq_oe)
	);

	// ==========================================================
	// mode load and spacing counters (remaining cycles)
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_ff     <= MODE_RST;
			mode_rem_ff <= '0;
			wr_rem_ff   <= '0;
		end else if (en) begin
			if (is_lmr) begin
				mode_ff     <= addr[MODE_W-1:0];
				mode_rem_ff <= MODE_LOAD_GAP - 2'h1; // [RQ10]
			end else if (mode_rem_ff != 2'h0) begin
				mode_rem_ff <= mode_rem_ff - 2'h1;
			end
			if (beat_live & beat_write) begin
				wr_rem_ff <= WRITE_TO_CLOSE_GAP - 2'h1; // [RQ6]
			end else if (wr_rem_ff != 2'h0) begin
				wr_rem_ff <= wr_rem_ff - 2'h1;
			end
		end
	end

	// ==========================================================
	// init and refresh tracking; timer runs on wall clock only
	wire logic ref_lapse = ready_ff & ~is_ref
		& (ref_timer_ff >= 32'(REFRESH_CYC - 1)); // [RQ13]

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_cnt_ff   <= '0;
			ref_timer_ff <= '0;
			ready_ff     <= 1'b0;
		end else if (clk_en) begin
			if (is_ref) begin
				ref_timer_ff <= '0;
				if (ref_cnt_ff != 2'(INIT_REFRESH_COUNT)) begin
					ref_cnt_ff <= ref_cnt_ff + 2'h1; // [RQ12]
				end
			end else if (ref_lapse) begin
				ref_cnt_ff   <= '0; // [RQ13]
				ref_timer_ff <= '0;
			end else if (ready_ff) begin
				ref_timer_ff <= ref_timer_ff + 32'h1;
			end
			ready_ff <= ~ref_lapse
				& ((ref_cnt_ff == 2'(INIT_REFRESH_COUNT))
				| (is_ref & (ref_cnt_ff == 2'(INIT_REFRESH_COUNT - 1))));
		end
	end

	// ==========================================================
	// sticky error flags; a new event wins over a clear
	wire logic [ERR_W-1:0] err_set;
	assign err_set[ERR_CLOSED_BANK] = rw_req & ~open_mask[bank]; // [RQ16]
	assign err_set[ERR_MODE_GAP]    = (is_act | is_ref)
		& (mode_rem_ff != 2'h0); // [RQ10]
	assign err_set[ERR_CLOSE_GAP]   = is_pre & (wr_rem_ff != 2'h0); // [RQ6]
	assign err_set[ERR_REF_LAPSE]   = ref_lapse;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			err_ff <= '0;
		end else if (clk_en) begin
			err_ff <= err_set | (err_ff & ~{ERR_W{err_clear}});
		end
	end

	// ==========================================================
	// outputs, all from flops
	assign ready                = ready_ff;
	assign power_down           = pd_ff;
	assign clock_suspend        = susp_ff;
	assign read_latency_setting = mode_ff[MODE_LAT_LSB +: MODE_LAT_W];
	assign protocol_error       = err_ff;

endmodule : sdcti_top
`default_nettype wire

/* File: rtl/sdcti_pkg.sv */
// constants, field layout and command codes of the sdram command timing block
package sdcti_pkg;

	// ==========================================================
	// organisation (x16 variant)
	localparam int BANKS    = 4;
	localparam int ROWS     = 8192;
	localparam int ROW_W    = 13;
	localparam int COL_W    = 10;
	localparam int COLS     = 1024;
	localparam int DQ_W     = 16;
	localparam int DM_W     = 2;
	localparam int LANE_W   = 8;
	localparam int ADDR_W   = 13;
	localparam int BANK_W   = 2;

	// ==========================================================
	// address bit positions
	localparam int AUTO_CLOSE_SELECT_BIT = 10;

	// ==========================================================
	// mode word layout and reset value
	localparam int MODE_W        = 13;
	localparam int MODE_BL_LSB   = 0;
	localparam int MODE_BL_W     = 3;
	localparam int MODE_ORDER_BIT = 3;
	localparam int MODE_LAT_LSB  = 4;
	localparam int MODE_LAT_W    = 3;
	localparam logic [MODE_W-1:0] MODE_RST = 13'h0020;
	localparam logic [MODE_LAT_W-1:0] LAT_THREE = 3'h3;

	// ==========================================================
	// clock-cycle spacings and latencies
	localparam int GATE_OFF_LATENCY    = 1;
	localparam int GATE_ON_LATENCY     = 1;
	localparam int MASK_TO_INPUT_DELAY = 0;
	localparam int MASK_TO_FLOAT_DELAY = 2;
	localparam int WRITE_CMD_TO_DATA_DELAY = 0;
	localparam logic [1:0] MODE_LOAD_GAP      = 2'h2;
	localparam logic [1:0] WRITE_TO_CLOSE_GAP = 2'h2;
	localparam int INIT_REFRESH_COUNT  = 2;

	// ==========================================================
	// refresh interval: time in ms, count derived from 25 MHz
	localparam int CLK_KHZ             = 25000;
	localparam int REFRESH_INTERVAL_MS = 64;
	localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_MS * CLK_KHZ;

	// ==========================================================
	// on-chip store (flip-flops), indexed by {bank, row bit, column}
	localparam int STORE_AW    = 6;
	localparam int STORE_DEPTH = 64;

	// ==========================================================
	// error flag positions
	localparam int ERR_CLOSED_BANK = 0;
	localparam int ERR_MODE_GAP    = 1;
	localparam int ERR_CLOSE_GAP   = 2;
	localparam int ERR_REF_LAPSE   = 3;
	localparam int ERR_W           = 4;

	// ==========================================================
	// command code {row strobe, column strobe, write enable}, low active
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR  = 3'h4,
		CMD_RD  = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} sdcti_cmd_t;

	// burst engine state
	typedef enum logic [1:0] {
		BS_IDLE  = 2'h0,
		BS_READ  = 2'h1,
		BS_WRITE = 2'h2
	} sdcti_burst_t;

endpackage : sdcti_pkg

/* File: rtl/sdcti_bank_table.sv */
// per-bank open flag and open row of the sdram model
`timescale 1ns/10ps
`default_nettype none
module sdcti_bank_table
	import sdcti_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              en,
	// open a row
	input  wire logic              act,
	input  wire logic [BANK_W-1:0] act_bank,
	input  wire logic [ROW_W-1:0]  act_row,
	// close requests
	input  wire logic              close_all,
	input  wire logic              close_one,
	input  wire logic [BANK_W-1:0] close_bank,
	input  wire logic              close_auto,
	input  wire logic [BANK_W-1:0] auto_bank,
	// lookup
	input  wire logic [BANK_W-1:0] sel_bank,
	output logic      [BANKS-1:0]  open_mask,
	output logic      [ROW_W-1:0]  sel_row
);

	// ==========================================================
	// bank state
	logic [ROW_W-1:0] row_vec [BANKS];

	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank
			logic             open_ff;
			logic [ROW_W-1:0] row_ff;
			wire logic hit_close = close_all
				| (close_one & (close_bank == BANK_W'(b)))
				| (close_auto & (auto_bank == BANK_W'(b)));
			wire logic hit_act = act & (act_bank == BANK_W'(b));
			// a close wins over an open in the same cycle
			always_ff @(posedge core_clk) begin
				if (rst) begin
					open_ff <= 1'b0;
					row_ff  <= '0;
				end else if (en) begin
					if (hit_close) begin
						open_ff <= 1'b0; // [RQ21]
					end else if (hit_act) begin
						open_ff <= 1'b1; // [RQ17]
						row_ff  <= act_row;
					end
				end
			end
			assign open_mask[b] = open_ff;
			assign row_vec[b]   = row_ff;
		end
	endgenerate

	// row of the bank being accessed
	assign sel_row = row_vec[sel_bank];

endmodule : sdcti_bank_table
`default_nettype wire

/* File: rtl/sdcti_read_pipe.sv */
// read latency pipeline with two-cycle mask-to-float delay
`timescale 1ns/10ps
`default_nettype none
module sdcti_read_pipe
	import sdcti_pkg::*;
(
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst,
	input  wire logic            adv,
	// launch side
	input  wire logic            launch_valid,
	input  wire logic [DQ_W-1:0] launch_data,
	input  wire logic [DM_W-1:0] dqm,
	input  wire logic            lat3,
	// pins
	output logic      [DQ_W-1:0] dq_out,
	output logic      [DQ_W-1:0] dq_oe
);

	// ==========================================================
	// pipeline stages
	logic [DQ_W-1:0] data_ff [3];
	logic [2:0]      val_ff;
	logic [DM_W-1:0] dm_ff [2];

	// tap chosen by read latency: stage 1 for two, stage 2 for three
	wire logic [DQ_W-1:0] tap_data  = lat3 ? data_ff[2] : data_ff[1];
	wire logic            tap_valid = lat3 ? val_ff[2] : val_ff[1];

	// stages freeze while the internal clock is suspended
	always_ff @(posedge core_clk) begin
		if (rst) begin
			val_ff  <= '0;
			data_ff <= '{default: '0};
			dm_ff   <= '{default: '0};
		end else if (adv) begin
			val_ff     <= {val_ff[1:0], launch_valid};
			data_ff[0] <= launch_data;
			data_ff[1] <= data_ff[0];
			data_ff[2] <= data_ff[1];
			dm_ff[0]   <= dqm;
			dm_ff[1]   <= dm_ff[0]; // [RQ8]
		end
	end

	// per-lane drive: mask seen two edges earlier floats the lane
	genvar l;
	generate
		for (l = 0; l < DM_W; l++) begin : g_lane
			always_ff @(posedge core_clk) begin
				if (rst) begin
					dq_out[l*LANE_W +: LANE_W] <= '0;
					dq_oe[l*LANE_W +: LANE_W]  <= '0;
				end else if (adv) begin
					dq_out[l*LANE_W +: LANE_W] <= tap_data[l*LANE_W +: LANE_W];
					dq_oe[l*LANE_W +: LANE_W]  <=
						{LANE_W{tap_valid & ~dm_ff[1][l]}}; // [RQ8] [RQ11]
				end
			end
		end
	endgenerate

endmodule : sdcti_read_pipe
`default_nettype wire

/* File: test/sdcti_top_chk.sv */
// port checker of the sdram command timing block
`timescale 1ns/10ps
`default_nettype none
module sdcti_top_chk
	import sdcti_pkg::*;
#(
	parameter int REFRESH_CYC = REFRESH_INTERVAL_CYC
) (
	// clock, reset, enable
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire logic                  clk_en,
	// command pins
	input wire logic                  cke,
	input wire logic                  cs_n,
	input wire logic                  ras_n,
	input wire logic                  cas_n,
	input wire logic                  we_n,
	input wire logic [ADDR_W-1:0]     addr,
	input wire logic [DM_W-1:0]       dqm,
	// device outputs
	input wire logic [DQ_W-1:0]       dq_oe,
	input wire logic                  ready,
	input wire logic                  power_down,
	input wire logic                  clock_suspend,
	input wire logic [MODE_LAT_W-1:0] read_latency_setting,
	input wire logic [ERR_W-1:0]      protocol_error
);
	// ==========================================================
	// decode: run means the gate is open, take means a command lands
	wire logic [2:0]            cmd;
	wire logic                  run;
	wire logic                  take;
	wire logic                  acc;
	wire logic [MODE_LAT_W-1:0] lat_in;
	assign cmd    = {ras_n, cas_n, we_n};
	assign run    = clk_en && !power_down && !clock_suspend;
	assign take   = run && !cs_n;
	assign acc    = take && (cmd == CMD_RD || cmd == CMD_WR);
	assign lat_in = addr[MODE_LAT_LSB +: MODE_LAT_W];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// properties
	property p_rst_vals;
		$fell(rst) |-> dq_oe == '0 && protocol_error == '0 && !ready
			&& !power_down && read_latency_setting == 3'h2;
	endproperty
	a_rst_vals: assert property (p_rst_vals)
		else $error("outputs not at reset values");
	property p_gate_off;
		clk_en && !cke |=> power_down || clock_suspend;
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("gate low did not stop the clock");
	property p_gate_on;
		clk_en && cke && (power_down || clock_suspend)
			|=> !power_down && !clock_suspend;
	endproperty
	a_gate_on: assert property (p_gate_on)
		else $error("gate high did not resume");
	property p_mask_float;
		run && dqm[0] ##1 run [*2] |=> !dq_oe[0];
	endproperty
	a_mask_float: assert property (p_mask_float)
		else $error("masked lane still driven");
	property p_mode_gap;
		take && cmd == CMD_LMR ##1 take && (cmd == CMD_ACT
			|| cmd == CMD_REF) |=> protocol_error[ERR_MODE_GAP];
	endproperty
	a_mode_gap: assert property (p_mode_gap)
		else $error("short mode gap not flagged");
	property p_closed_bank;
		$rose(protocol_error[ERR_CLOSED_BANK]) |-> $past(acc);
	endproperty
	a_closed_bank: assert property (p_closed_bank)
		else $error("closed bank flag without access");
	property p_close_float;
		take && cmd == CMD_PRE && addr[AUTO_CLOSE_SELECT_BIT]
			&& read_latency_setting == LAT_THREE ##1 run [*3]
			|=> dq_oe == '0;
	endproperty
	a_close_float: assert property (p_close_float)
		else $error("output not floated after close");
	property p_lat_load;
		take && cmd == CMD_LMR |=> read_latency_setting == $past(lat_in);
	endproperty
	a_lat_load: assert property (p_lat_load)
		else $error("latency field not loaded");
endmodule : sdcti_top_chk

bind sdcti_top sdcti_top_chk #(.REFRESH_CYC(REFRESH_CYC)) u_chk (
	.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .cke(cke),
	.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.addr(addr), .dqm(dqm), .dq_oe(dq_oe), .ready(ready),
	.power_down(power_down), .clock_suspend(clock_suspend),
	.read_latency_setting(read_latency_setting),
	.protocol_error(protocol_error));
`default_nettype wire

/* File: test/sdcti_ctl_model.sv */
// memory controller model driving the sdram command pins
`timescale 1ns/10ps
`default_nettype none
module sdcti_ctl_model
	import sdcti_pkg::*;
(
	// clock
	input  wire logic              core_clk,
	// command and data pins
	output var logic               cs_n,
	output var logic               ras_n,
	output var logic               cas_n,
	output var logic               we_n,
	output var logic               bank_select_bit0,
	output var logic               bank_select_bit1,
	output var logic [ADDR_W-1:0]  addr,
	output var logic [DM_W-1:0]    dqm,
	output var logic [DQ_W-1:0]    dq_in
);
	// ==========================================================
	// pins deselected from time zero
	initial begin
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = CMD_NOP;
		{bank_select_bit1, bank_select_bit0} = 2'h0;
		addr = '0;
		dqm = '0;
		dq_in = 16'h5A5A;
	end

	// one command a cycle, launched at the falling edge for the next rise
	task automatic issue(input sdcti_cmd_t c, input logic [1:0] b,
		input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d,
		input logic [DM_W-1:0] m);
		@(negedge core_clk);
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = c;
		{bank_select_bit1, bank_select_bit0} = b;
		addr = a;
		dq_in = (c == CMD_WR) ? d : ~dq_in;
		dqm = m;
	endtask : issue

	// deselected cycles; a released data bus never keeps its last value
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge core_clk);
			cs_n = 1'b1;
			dqm = '0;
			dq_in = ~dq_in;
		end
	endtask : idle
endmodule : sdcti_ctl_model
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench of the sdram command timing block
`timescale 1ns/10ps
`default_nettype none
module tb
	import sdcti_pkg::*;
;
	// ==========================================================
	// short refresh interval keeps the lapse test brief
	localparam int RCYC = 1000;
	typedef struct packed {
		logic [1:0]  bank;
		logic [12:0] row;
		logic [9:0]  col;
		logic [15:0] data;
		logic [1:0]  wm;
		logic [1:0]  rm;
		logic [15:0] want;
	} sdcti_vec_t;
	// bank, row, column, data, write mask, read mask, expected read
	sdcti_vec_t vec [8] = '{
		'{2'h0, 13'h0000, 10'h000, 16'h1234, 2'h0, 2'h0, 16'h1234},
		'{2'h3, 13'h1FFF, 10'h3FF, 16'hABCD, 2'h0, 2'h0, 16'hABCD},
		'{2'h0, 13'h0000, 10'h000, 16'hFFFF, 2'h1, 2'h0, 16'hFF34},
		'{2'h3, 13'h1FFF, 10'h3FF, 16'h0000, 2'h0, 2'h2, 16'h0000},
		'{2'h1, 13'h0001, 10'h005, 16'h5A5A, 2'h0, 2'h1, 16'h5A5A},
		'{2'h2, 13'h0000, 10'h002, 16'hC3C3, 2'h0, 2'h0, 16'hC3C3},
		'{2'h2, 13'h0001, 10'h002, 16'h0F0F, 2'h0, 2'h0, 16'h0F0F},
		'{2'h2, 13'h0000, 10'h002, 16'h0000, 2'h3, 2'h0, 16'hC3C3}};

	// clock, controls and observed pins
	logic                  core_clk = 1'b0;
	logic                  rst;
	logic                  clk_en;
	logic                  cke;
	logic                  err_clear;
	wire logic             cs_n, ras_n, cas_n, we_n, bsel0, bsel1;
	wire logic [ADDR_W-1:0] addr;
	wire logic [DM_W-1:0]  dqm;
	wire logic [DQ_W-1:0]  dq_in, dq_out, dq_oe;
	wire logic             ready, power_down, clock_suspend;
	wire logic [MODE_LAT_W-1:0] lat;
	wire logic [ERR_W-1:0] err;
	int                    n_mismatch = 0;
	int                    cmp_count = 0;
	always #20 core_clk = ~core_clk;

	sdcti_ctl_model ctl (.core_clk(core_clk), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_select_bit0(bsel0),
		.bank_select_bit1(bsel1), .addr(addr), .dqm(dqm), .dq_in(dq_in));
	sdcti_top #(.REFRESH_CYC(RCYC)) dut (.core_clk(core_clk), .rst(rst),
		.clk_en(clk_en), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_select_bit0(bsel0),
		.bank_select_bit1(bsel1), .addr(addr), .dqm(dqm), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .err_clear(err_clear),
		.ready(ready), .power_down(power_down),
		.clock_suspend(clock_suspend), .read_latency_setting(lat),
		.protocol_error(err));

	// ==========================================================
	// helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h",
				$time, seen, want);
		end
	endtask : check
	task automatic op(input sdcti_cmd_t c, input logic [1:0] b,
		input logic [ADDR_W-1:0] a);
		ctl.issue(c, b, a, 16'h0000, 2'h0);
	endtask : op
	task automatic clr();
		err_clear = 1'b1;
		ctl.idle(1);
		err_clear = 1'b0;
	endtask : clr
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// watchdog: the tests need about 1150 cycles
	initial begin
		#(4000 * 40);
		n_mismatch++;
		stop_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		sdcti_vec_t  v;
		logic [15:0] oe;
		rst = 1'b1;
		clk_en = 1'b1;
		cke = 1'b1;
		err_clear = 1'b0;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		check(16'(lat), 16'h0002);
		op(CMD_REF, 2'h0, 13'h0);
		ctl.idle(2);
		check(16'(ready), 16'h0000);
		op(CMD_REF, 2'h0, 13'h0);
		ctl.idle(2);
		check(16'(ready), 16'h0001);
		// mode load followed at once by an open is flagged
		op(CMD_LMR, 2'h0, 13'h020);
		op(CMD_ACT, 2'h0, 13'h0);
		ctl.idle(2);
		check(16'(err), 16'h0002);
		clr();
		op(CMD_PRE, 2'h0, 13'h400);
		ctl.idle(1);
		op(CMD_LMR, 2'h0, 13'h020);
		ctl.idle(2);
		$display("init and mode gap done");
		// write then read back each row of the table
		foreach (vec[i]) begin
			v = vec[i];
			op(CMD_ACT, v.bank, v.row);
			ctl.issue(CMD_WR, v.bank, {3'h0, v.col}, v.data, v.wm);
			ctl.idle(1);
			ctl.issue(CMD_RD, v.bank, {3'h0, v.col}, 16'h0, v.rm);
			ctl.idle(3);
			oe = {{8{~v.rm[1]}}, {8{~v.rm[0]}}};
			check(dq_oe, oe);
			check(dq_out & oe, v.want & oe);
			ctl.idle(1);
		end
		check(16'(err), 16'h0000);
		$display("table done");
		// auto close write, then a read to the now closed bank
		op(CMD_ACT, 2'h1, 13'h0);
		ctl.issue(CMD_WR, 2'h1, 13'h403, 16'h7E7E, 2'h0);
		ctl.idle(2);
		op(CMD_RD, 2'h1, 13'h003);
		ctl.idle(2);
		check(16'(err), 16'h0001);
		clr();
		// close all banks in mid read at the longer latency
		op(CMD_PRE, 2'h0, 13'h400);
		ctl.idle(2);
		op(CMD_LMR, 2'h0, 13'h032);
		ctl.idle(2);
		check(16'(lat), 16'h0003);
		op(CMD_ACT, 2'h0, 13'h0);
		op(CMD_RD, 2'h0, 13'h0);
		op(CMD_PRE, 2'h0, 13'h400);
		ctl.idle(3);
		check(dq_out, 16'hFF34);
		ctl.idle(1);
		check(dq_oe, 16'h0000);
		$display("close in read done");
		// gate low: idle power down, gated command ignored
		cke = 1'b0;
		ctl.idle(1);
		check(16'(power_down), 16'h0001);
		op(CMD_RD, 2'h0, 13'h0);
		cke = 1'b1;
		ctl.idle(1);
		check(16'(err) | 16'(power_down), 16'h0000);
		op(CMD_RD, 2'h0, 13'h0);
		ctl.idle(2);
		check(16'(err), 16'h0001);
		clr();
		// gate low mid burst, early close
		op(CMD_ACT, 2'h0, 13'h0);
		ctl.issue(CMD_WR, 2'h0, 13'h0, 16'h1111, 2'h0);
		ctl.idle(1);
		cke = 1'b0;
		ctl.idle(1);
		check(16'(clock_suspend), 16'h0001);
		cke = 1'b1;
		op(CMD_PRE, 2'h0, 13'h400);
		ctl.idle(1);
		check(16'(err), 16'h0004);
		clr();
		// clock enable low freezes all
		clk_en = 1'b0;
		cke = 1'b0;
		op(CMD_LMR, 2'h0, 13'h020);
		cke = 1'b1;
		ctl.idle(1);
		clk_en = 1'b1;
		check(16'({power_down, lat}), 16'h0003);
		$display("gating done");
		// refresh lapse needs two refreshes again
		ctl.idle(RCYC + 20);
		check(16'(ready), 16'h0000);
		check(16'(err), 16'h0008);
		op(CMD_REF, 2'h0, 13'h0);
		ctl.idle(1);
		op(CMD_REF, 2'h0, 13'h0);
		ctl.idle(2);
		check(16'(ready), 16'h0001);
		// reset in mid run
		rst = 1'b1;
		ctl.idle(2);
		rst = 1'b0;
		check(16'({ready, lat}), 16'h0002);
		$display("lapse and reset done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
